// ===== bmdg_cpu_model.sv
// Processor-side model: free-running clock and multiplexed bus cycles
`timescale 1ns/1ps
module bmdg_cpu_model (
  // Clock
  input  wire logic       mclk_i,
  // Processor pins
  output logic            cpu_clk_o,
  output logic            ale_o,
  output logic [7:0]      ad_o,
  output logic [7:0]      addr_hi_o
);
  logic [2:0] div;

  initial
  begin
    div = 3'h0;
    cpu_clk_o = 1'b0;
    ale_o = 1'b0;
    ad_o = 8'h00;
    addr_hi_o = 8'h00;
  end

  // Processor clock at one sixteenth of mclk, close to its nominal rate
  always @(negedge mclk_i)
  begin
    div <= div + 3'h1;
    if (div == 3'h7)
      cpu_clk_o <= ~cpu_clk_o;
  end

  task automatic bus_cycle(input logic [15:0] a, input int hold);
    @(negedge mclk_i);
    ale_o = 1'b1;
    ad_o = a[7:0];
    addr_hi_o = a[15:8];
    repeat (3) @(negedge mclk_i);
    ale_o = 1'b0;
    // Data phase: the shared lines no longer carry the low address
    ad_o = ~a[7:0];
    repeat (hold) @(negedge mclk_i);
  endtask
endmodule

// ===== bmdg_glue.sv
// Board glue: power-on reset, address latch, decoder, RAM wait and timer
// How it works
// - After power-up the processor reset is held active, so the processor starts at address 0000 on release.
// - The low address byte is caught from the shared lines while the latch strobe is high and joined to the high byte.
// - The high address bits are decoded into one select for each memory and each port device.
// - Program memory one answers at 0000-07FF and program memory two at 0800-0FFF.
// - The read/write memory answers at 4000-43FF.
// - A jumper input chooses between 1K-byte and 2K-byte program memory decode.
// - With slow memories fitted, each read/write memory access is stretched by one processor clock.
// - The processor clock is divided into eight periods of 4, then 256 to 16384 clocks, and one is chosen.
// - The chosen timer output leaves the block and, by a jumper, also drives the top restart interrupt.
// - An extension input lets off-board logic take memory cycles by silencing on-board memory selects.
// - Port device one answers at 6000-6FFF and port device two at 7000-7FFF, the whole 4K window each.
`timescale 1ns/1ps
module bmdg_glue
  import bmdg_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk_i,
  input  wire logic        reset_i,
  // Processor bus pins
  input  wire logic [7:0]  ad_i,
  input  wire logic [7:0]  addr_hi_i,
  input  wire logic        ale_i,
  input  wire logic        cpu_clk_i,
  // Jumpers and extension
  input  wire logic        rom_2k_i,
  input  wire logic        ram_slow_i,
  input  wire logic        ext_mem_i,
  input  wire logic        tmr_irq_en_i,
  input  wire logic [2:0]  tmr_sel_i,
  // Processor control
  output logic             cpu_reset_o,
  output logic             ready_o,
  output logic             rst75_o,
  // Address bus and selects
  output logic [15:0]      addr_o,
  output logic             rom0_cs_n_o,
  output logic             rom1_cs_n_o,
  output logic             ram_cs_n_o,
  output logic             port0_cs_n_o,
  output logic             port1_cs_n_o,
  // Timer output
  output logic             tmr_o
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [SYNC_W-1:0] sync_a;
  logic [SYNC_W-1:0] sync_b;
  logic [7:0]        ad_s;
  logic [7:0]        ahi_s;
  logic              ale_s;
  logic              cclk_s;
  logic              rom2k_s;
  logic              slow_s;
  logic              ext_s;
  logic              irqen_s;
  logic [2:0]        sel_s;

  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      sync_a <= '0;
      sync_b <= '0;
    end
    else
    begin
      sync_a <= {ad_i, addr_hi_i, ale_i, cpu_clk_i, rom_2k_i, ram_slow_i, ext_mem_i, tmr_irq_en_i, tmr_sel_i};
      sync_b <= sync_a;
    end
  end

  assign {ad_s, ahi_s, ale_s, cclk_s, rom2k_s, slow_s, ext_s, irqen_s, sel_s} = sync_b;

  // ****************************************
  // Power-on reset
  // ****************************************
  logic [POR_CNT_W-1:0] por_cnt;
  logic                 por_done;

  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      por_cnt     <= '0;
      por_done    <= 1'b0;
      cpu_reset_o <= 1'b1;
    end
    else
    begin
      if (!por_done)
        por_cnt <= por_cnt + POR_CNT_W'(1);
      if (por_cnt == POR_LAST)
        por_done <= 1'b1;
      cpu_reset_o <= ~por_done;
    end
  end

  // ****************************************
  // Address latch and decoder
  // ****************************************
  logic [7:0]       lo_lat;
  logic [15:0]      addr_lat;
  logic [SEL_W-1:0] sel_now;
  logic [SEL_W-1:0] sel_lat;

  // Port decode is deliberately partial: the whole 4K window answers
  function automatic logic [SEL_W-1:0] bmdg_decode(input logic [15:0] a,
                                                   input logic        rom_2k,
                                                   input logic        ext);
    logic [SEL_W-1:0] s;
    s = '0;
    if (!ext && (rom_2k || !a[ROM_1K_BIT]) && a[15:11] == ROM0_TAG)
      s[SEL_ROM0] = 1'b1;
    else if (!ext && (rom_2k || !a[ROM_1K_BIT]) && a[15:11] == ROM1_TAG)
      s[SEL_ROM1] = 1'b1;
    else if (!ext && a[15:10] == RAM_TAG)
      s[SEL_RAM] = 1'b1;
    else if (a[15:12] == PORT0_TAG)
      s[SEL_PORT0] = 1'b1;
    else if (a[15:12] == PORT1_TAG)
      s[SEL_PORT1] = 1'b1;
    return s;
  endfunction

  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
      lo_lat <= 8'h00;
    else if (ale_s)
      lo_lat <= ad_s;
  end

  assign addr_lat = {ahi_s, lo_lat};
  assign sel_now  = bmdg_decode(addr_o, rom2k_s, ext_s);
  assign sel_lat  = bmdg_decode(addr_lat, rom2k_s, ext_s);

  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      addr_o       <= RESET_VECTOR;
      rom0_cs_n_o  <= 1'b1;
      rom1_cs_n_o  <= 1'b1;
      ram_cs_n_o   <= 1'b1;
      port0_cs_n_o <= 1'b1;
      port1_cs_n_o <= 1'b1;
    end
    else
    begin
      addr_o       <= addr_lat;
      rom0_cs_n_o  <= ~sel_now[SEL_ROM0];
      rom1_cs_n_o  <= ~sel_now[SEL_ROM1];
      ram_cs_n_o   <= ~sel_now[SEL_RAM];
      port0_cs_n_o <= ~sel_now[SEL_PORT0];
      port1_cs_n_o <= ~sel_now[SEL_PORT1];
    end
  end

  // ****************************************
  // Wait generation
  // ****************************************
  logic       ale_d;
  logic       cclk_d;
  logic       ale_fall;
  logic       cclk_rise;
  logic [1:0] wait_cnt;

  assign ale_fall  = ale_d & ~ale_s;
  assign cclk_rise = cclk_s & ~cclk_d;

  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      ale_d  <= 1'b0;
      cclk_d <= 1'b0;
    end
    else
    begin
      ale_d  <= ale_s;
      cclk_d <= cclk_s;
    end
  end

  // Two processor clock rises span the ready sample, giving one wait state
  // stretch slow memory only
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      wait_cnt <= 2'h0;
      ready_o  <= 1'b1;
    end
    else if (ale_fall && slow_s && sel_lat[SEL_RAM])
    begin
      wait_cnt <= WAIT_EDGES;
      ready_o  <= 1'b0;
    end
    else if (wait_cnt != 2'h0 && cclk_rise)
    begin
      wait_cnt <= wait_cnt - 2'h1;
      ready_o  <= (wait_cnt == 2'h1);
    end
  end

  // ****************************************
  // Timer
  // ****************************************
  logic [TMR_CNT_W-1:0] tmr_cnt;
  logic [2:0]           tmr_sel_q;
  logic [7:0]           taps;

  assign taps = {tmr_cnt[TMR_CNT_W-1:TMR_SLOW_TAP0], tmr_cnt[TMR_FAST_TAP]};

  // choice taken once, while processor reset still holds
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
      tmr_sel_q <= 3'h0;
    else if (!por_done)
      tmr_sel_q <= sel_s;
  end

  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      tmr_cnt <= '0;
      tmr_o   <= 1'b0;
      rst75_o <= 1'b0;
    end
    else
    begin
      if (cclk_rise)
        tmr_cnt <= tmr_cnt + TMR_CNT_W'(1);
      tmr_o   <= taps[tmr_sel_q];
      rst75_o <= taps[tmr_sel_q] & irqen_s;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (reset_i);

  sequence seq_slow_start;
    ale_fall && slow_s && sel_lat[SEL_RAM];
  endsequence

  sequence seq_wait_end;
    !ready_o ##[1:200] ready_o;
  endsequence

  chk_por_hold: assert property ($rose(por_done) |-> $past(cpu_reset_o, 1) && cpu_reset_o ##1 !cpu_reset_o)
    else $error("processor reset not held until power-on count ends");
  chk_addr_latch: assert property ($fell(ale_s) |-> ##1 addr_o[7:0] == $past(ad_s, 2))
    else $error("low address byte not latched");
  chk_cs_onehot: assert property ($onehot0(~{rom0_cs_n_o, rom1_cs_n_o, ram_cs_n_o, port0_cs_n_o, port1_cs_n_o}))
    else $error("more than one select active");
  chk_rom_map: assert property (rom2k_s && !ext_s && addr_o[15:11] == ROM1_TAG |=> !rom1_cs_n_o && rom0_cs_n_o)
    else $error("second program memory not selected");
  chk_ram_map: assert property (!ext_s && addr_o[15:10] == RAM_TAG |=> !ram_cs_n_o)
    else $error("data memory not selected");
  chk_rom_jumper: assert property (!rom2k_s && addr_o[15:10] == 6'h01 |=> rom0_cs_n_o && rom1_cs_n_o)
    else $error("1K mode selected upper half");
  chk_ram_wait: assert property (seq_slow_start |=> seq_wait_end)
    else $error("slow memory wait missing or stuck");
  chk_no_wait: assert property (ale_fall && ready_o && !(slow_s && sel_lat[SEL_RAM]) |=> ready_o)
    else $error("wait inserted on a fast cycle");
  chk_ext_inhibit: assert property (ext_s |=> rom0_cs_n_o && rom1_cs_n_o && ram_cs_n_o)
    else $error("on-board memory selected during extension");
  chk_port_map: assert property (addr_o[15:12] == PORT1_TAG |=> !port1_cs_n_o)
    else $error("second port device not selected");
  chk_tmr_irq: assert property (!irqen_s |=> !rst75_o)
    else $error("restart interrupt driven with jumper open");
  chk_tmr_stable: assert property (por_done |=> $stable(tmr_sel_q))
    else $error("timer choice changed after reset");

endmodule

// ===== bmdg_pkg.sv
// Constants for the board memory decode glue block
package bmdg_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 25;
  // Power-on hold of the processor reset, least time
  localparam int POR_TIME_NS   = 10000;
  localparam int POR_CYC       = (POR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int POR_CNT_W     = 9;
  localparam logic [POR_CNT_W-1:0] POR_LAST = POR_CNT_W'(POR_CYC - 1);

  // ****************************************
  // Address map
  // ****************************************
  localparam logic [15:0] RESET_VECTOR = 16'h0000;
  localparam logic [4:0]  ROM0_TAG     = 5'h00;   // addr[15:11], 0000-07FF
  localparam logic [4:0]  ROM1_TAG     = 5'h01;   // addr[15:11], 0800-0FFF
  localparam int          ROM_1K_BIT   = 10;      // Must be low in 1K mode
  localparam logic [5:0]  RAM_TAG      = 6'h10;   // addr[15:10], 4000-43FF
  localparam logic [3:0]  PORT0_TAG    = 4'h6;    // addr[15:12], 6000-6FFF
  localparam logic [3:0]  PORT1_TAG    = 4'h7;    // addr[15:12], 7000-7FFF

  // ****************************************
  // Select vector layout
  // ****************************************
  localparam int SEL_ROM0  = 0;
  localparam int SEL_ROM1  = 1;
  localparam int SEL_RAM   = 2;
  localparam int SEL_PORT0 = 3;
  localparam int SEL_PORT1 = 4;
  localparam int SEL_W     = 5;

  // ****************************************
  // Timer and wait
  // ****************************************
  localparam int TMR_CNT_W     = 14;
  localparam int TMR_FAST_TAP  = 1;   // 4 processor clocks, about 1.6 us
  localparam int TMR_SLOW_TAP0 = 7;   // 256 processor clocks, about 0.1 ms
  localparam int TMR_SEL_W     = 3;
  localparam logic [1:0] WAIT_EDGES = 2'h2;
  localparam int SYNC_W        = 25;

endpackage

// ===== tb_bmdg_glue.sv
// Self-checking testbench for the board glue block
`timescale 1ns/1ps
module tb_bmdg_glue;
  import bmdg_pkg::*;
  logic        mclk_i, reset_i, ale_i, cpu_clk_i, rom_2k_i, ram_slow_i, ext_mem_i, tmr_irq_en_i;
  logic [7:0]  ad_i, addr_hi_i;
  logic [2:0]  tmr_sel_i;
  logic        cpu_reset_o, ready_o, rst75_o, tmr_o;
  logic        rom0_cs_n_o, rom1_cs_n_o, ram_cs_n_o, port0_cs_n_o, port1_cs_n_o;
  logic [15:0] addr_o;
  int          err_count = 0;
  int          cmp_count = 0;
  logic [15:0] alist [20] = '{16'h0000, 16'h03FF, 16'h0400, 16'h07FF, 16'h0800, 16'h0C00, 16'h0FFF,
    16'h1000, 16'h3FFF, 16'h4000, 16'h43FF, 16'h4400, 16'h6000, 16'h6003, 16'h6FFF, 16'h7000,
    16'h7003, 16'h7FFF, 16'h8000, 16'hFFFF};

  bmdg_glue u_bmdg_glue (.mclk_i(mclk_i), .reset_i(reset_i), .ad_i(ad_i), .addr_hi_i(addr_hi_i),
    .ale_i(ale_i), .cpu_clk_i(cpu_clk_i), .rom_2k_i(rom_2k_i), .ram_slow_i(ram_slow_i),
    .ext_mem_i(ext_mem_i), .tmr_irq_en_i(tmr_irq_en_i), .tmr_sel_i(tmr_sel_i),
    .cpu_reset_o(cpu_reset_o), .ready_o(ready_o), .rst75_o(rst75_o), .addr_o(addr_o),
    .rom0_cs_n_o(rom0_cs_n_o), .rom1_cs_n_o(rom1_cs_n_o), .ram_cs_n_o(ram_cs_n_o),
    .port0_cs_n_o(port0_cs_n_o), .port1_cs_n_o(port1_cs_n_o), .tmr_o(tmr_o));

  bmdg_cpu_model u_bmdg_cpu_model (.mclk_i(mclk_i), .cpu_clk_o(cpu_clk_i), .ale_o(ale_i),
    .ad_o(ad_i), .addr_hi_o(addr_hi_i));

  initial
  begin
    mclk_i = 1'b0;
    forever #12.5 mclk_i = ~mclk_i;
  end

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Active-high select set {port1, port0, ram, rom1, rom0} for an address
  function automatic logic [4:0] exp_sel(input logic [15:0] a, input logic k2, input logic ext);
    exp_sel[0] = !ext && a[15:11] == 5'h00 && (k2 || !a[10]);
    exp_sel[1] = !ext && a[15:11] == 5'h01 && (k2 || !a[10]);
    exp_sel[2] = !ext && a[15:10] == 6'h10;
    exp_sel[3] = a[15:12] == 4'h6;
    exp_sel[4] = a[15:12] == 4'h7;
  endfunction

  task automatic do_reset(input logic [2:0] sel);
    int n;
    @(negedge mclk_i);
    reset_i = 1'b1;
    tmr_sel_i = sel;
    repeat (20) @(negedge mclk_i);
    check("cpu_reset", cpu_reset_o, 16'h0001);
    check("selects", {port1_cs_n_o, port0_cs_n_o, ram_cs_n_o, rom1_cs_n_o, rom0_cs_n_o}, 16'h001F);
    reset_i = 1'b0;
    n = 0;
    while (cpu_reset_o !== 1'b0 && n < 1000)
    begin
      @(negedge mclk_i);
      n++;
    end
    if (n >= 1000)
    begin
      err_count++;
      report_and_stop();
    end
    check("por_length_ok", 16'(n >= 400 && n <= 404), 16'h0001);
    $display("test reset done");
  endtask

  task automatic test_decode(input logic k2, input logic ext);
    rom_2k_i = k2;
    ext_mem_i = ext;
    ram_slow_i = 1'b0;
    foreach (alist[i])
    begin
      u_bmdg_cpu_model.bus_cycle(alist[i], 8);
      check("addr", addr_o, alist[i]);
      check("selects", {port1_cs_n_o, port0_cs_n_o, ram_cs_n_o, rom1_cs_n_o, rom0_cs_n_o},
            {11'h000, ~exp_sel(alist[i], k2, ext)});
    end
    $display("test decode done");
  endtask

  task automatic test_wait;
    logic [15:0] wa [3] = '{16'h4010, 16'h0000, 16'h4010};
    logic        ws [3] = '{1'b1, 1'b1, 1'b0};
    int n;
    rom_2k_i = 1'b1;
    ext_mem_i = 1'b0;
    for (int i = 0; i < 3; i++)
    begin
      ram_slow_i = ws[i];
      repeat (4) @(negedge mclk_i);
      u_bmdg_cpu_model.bus_cycle(wa[i], 0);
      n = 0;
      repeat (80)
      begin
        @(negedge mclk_i);
        if (ready_o !== 1'b1)
          n++;
      end
      // One processor clock is 16 mclk; the stretch spans at most two of them
      check("wait_len_ok", 16'(i == 0 ? (n >= 16 && n <= 40) : (n == 0)), 16'h0001);
    end
    $display("test wait done");
  endtask

  task automatic test_timer(input int exp_high);
    int n;
    for (int k = 0; k < 2; k++)
    begin
      n = 0;
      while (tmr_o !== 1'b0 && n < 8000)
      begin
        @(negedge mclk_i);
        n++;
      end
      while (tmr_o !== 1'b1 && n < 8000)
      begin
        @(negedge mclk_i);
        n++;
      end
      if (n >= 8000)
      begin
        err_count++;
        report_and_stop();
      end
      n = 0;
      while (tmr_o === 1'b1 && n < 8000)
      begin
        check("rst75", rst75_o, 16'h0001);
        @(negedge mclk_i);
        n++;
      end
      check("tmr_high", 16'(n), 16'(exp_high));
      tmr_sel_i = ~tmr_sel_i;
    end
    tmr_irq_en_i = 1'b0;
    n = 0;
    repeat (2 * exp_high + 8)
    begin
      @(negedge mclk_i);
      n += int'(rst75_o !== 1'b0);
    end
    // Tap has just gone low, so an open jumper must keep the interrupt quiet through the next high phase
    check("rst75_gated", 16'(n), 16'h0000);
    tmr_irq_en_i = 1'b1;
    $display("test timer done");
  endtask

  initial
  begin
    reset_i = 1'b1;
    rom_2k_i = 1'b1;
    ram_slow_i = 1'b0;
    ext_mem_i = 1'b0;
    tmr_irq_en_i = 1'b1;
    tmr_sel_i = 3'h0;
    do_reset(3'h0);
    test_decode(1'b1, 1'b0);
    test_decode(1'b0, 1'b0);
    test_decode(1'b1, 1'b1);
    test_wait();
    test_timer(32);
    do_reset(3'h1);
    test_timer(2048);
    report_and_stop();
  end
endmodule
